// *** bench/serial_wiper_latch_interface_test.sv ***
`timescale 1ns/1ps
module serial_wiper_latch_interface_test;
  import swl_pkg::*;
  logic            mclk, rst_n, mrst_n, pd_n, sclk, sel_n, ser_in, so, so_oe_n;
  logic [3:0][7:0] wl, exp;
  logic [3:0]      tao;
  logic            sel1_n, skip1;
  logic [0:0][7:0] wl1;
  logic [7:0]      exp1;
  int              mismatches = 0;
  int              tests_run = 0;
  swl_host_model u_host (.SCLK(sclk), .SELECT_N(sel_n), .SERIAL_IN(ser_in));
  swl_wiper_latch_if #(.CHANNELS(4)) u_dut (
    .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .SCLK(sclk), .SELECT_N(sel_n),
    .SERIAL_IN(ser_in), .MIDSCALE_RESET_N(mrst_n), .POWER_DOWN_N(pd_n),
    .SERIAL_OUT_O(so), .SERIAL_OUT_OE_N(so_oe_n), .WIPER_LATCH(wl), .TERM_A_OPEN(tao));
  // single variant is selected only for address zero
  assign sel1_n = sel_n | skip1;
  swl_wiper_latch_if #(.CHANNELS(1)) u_dut_single (
    .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .SCLK(sclk), .SELECT_N(sel1_n),
    .SERIAL_IN(ser_in), .MIDSCALE_RESET_N(mrst_n), .POWER_DOWN_N(pd_n),
    .SERIAL_OUT_O(), .SERIAL_OUT_OE_N(), .WIPER_LATCH(wl1), .TERM_A_OPEN());
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    skip1 = (a != 2'h0);
    u_host.send({a, d});
    exp[a] = d;
    if (a == 2'h0) exp1 = d;
    repeat (6) @(negedge mclk);
    check(wl, exp);
    check(wl1, exp1);
    check({so, so_oe_n}, {1'b0, ~pd_n | a[1]});
  endtask : wr
  task automatic test_write();
    wr(2'h0, 8'hFF);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h5A);
    wr(2'h3, 8'h81);
    wr(2'h3, 8'h7E);
    $display("write test done");
  endtask : test_write
  task automatic test_midscale();
    mrst_n = 1'b0;
    repeat (4) @(negedge mclk);
    mrst_n = 1'b1;
    exp = {4{MIDSCALE_CODE}};
    exp1 = MIDSCALE_CODE;
    @(negedge mclk);
    check(wl, exp);
    check(wl1, exp1);
    $display("midscale test done");
  endtask : test_midscale
  task automatic test_power_down();
    pd_n = 1'b0;
    repeat (4) @(negedge mclk);
    check(tao, 4'hF);
    wr(2'h2, 8'h3C);
    pd_n = 1'b1;
    repeat (4) @(negedge mclk);
    check({tao, wl[2]}, {4'h0, 8'h3C});
    $display("power-down test done");
  endtask : test_power_down
  task automatic test_stray();
    u_host.stray_clk(3);
    repeat (6) @(negedge mclk);
    check(so_oe_n, 1'b1);
    check(wl, exp);
    wr(2'h1, 8'hC3);
    $display("stray clock test done");
  endtask : test_stray
  task automatic test_reset();
    rst_n  = 1'b0;
    mrst_n = 1'b1;
    pd_n   = 1'b1;
    skip1  = 1'b0;
    exp    = {4{MIDSCALE_CODE}};
    exp1   = MIDSCALE_CODE;
    repeat (8) @(negedge mclk);
    check(wl, exp);
    check(wl1, exp1);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    $display("reset test done");
  endtask : test_reset
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    test_reset();
    test_write();
    test_midscale();
    test_power_down();
    test_stray();
    test_done();
  end
endmodule : serial_wiper_latch_interface_test

// *** bench/swl_host_model.sv ***
`timescale 1ns/1ps
module swl_host_model (
  output logic SCLK,
  output logic SELECT_N,
  output logic SERIAL_IN
);
  initial begin
    SCLK      = 1'b0;
    SELECT_N  = 1'b1;
    SERIAL_IN = 1'b0;
  end
  task automatic send(input logic [9:0] w);
    SELECT_N = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      SERIAL_IN = w[i];
      #3 SCLK = 1'b1;
      #3 SCLK = 1'b0;
    end
    #3 SELECT_N = 1'b1;
    // Released data line must not look valid
    SERIAL_IN = ~w[0];
  endtask : send
  task automatic stray_clk(input int n);
    for (int i = 0; i < n; i++) begin
      SERIAL_IN = ~SERIAL_IN;
      #3 SCLK = 1'b1;
      #3 SCLK = 1'b0;
    end
  endtask : stray_clk
endmodule : swl_host_model

// *** core/swl_pkg.sv ***
package swl_pkg;

  localparam int unsigned WORD_BITS     = 10;
  localparam int unsigned ADDR_BITS     = 2;
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [7:0]  MIDSCALE_CODE = 8'h80;
  localparam logic [3:0]  BIT_CNT_ZERO  = 4'h0;
  localparam logic [3:0]  BIT_CNT_ONE   = 4'h1;

  // Address decode of the two-bit channel field
  localparam logic [1:0]  ADDR_CH1      = 2'h0;
  localparam logic [1:0]  ADDR_CH2      = 2'h1;
  localparam logic [1:0]  ADDR_CH3      = 2'h2;
  localparam logic [1:0]  ADDR_CH4      = 2'h3;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] data;
  } swl_word_type;

  // Link-domain state
  typedef struct packed {
    swl_word_type shift;
    logic [3:0]   cnt;
  } swl_link_state_type;

  // Core-domain state
  typedef struct packed {
    logic [2:0]  sel_sync;
    logic [1:0]  pd_sync;
    logic [1:0]  mrst_sync;
    logic [3:0][7:0] latch;
  } swl_core_state_type;

endpackage : swl_pkg

// *** core/swl_wiper_latch_if.sv ***
`timescale 1ns/1ps
module swl_wiper_latch_if
  import swl_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                    MCLK,
  input  wire logic                    RST_N,
  input  wire logic                    CE,
  input  wire logic                    SCLK,
  input  wire logic                    SELECT_N,
  input  wire logic                    SERIAL_IN,
  input  wire logic                    MIDSCALE_RESET_N,
  input  wire logic                    POWER_DOWN_N,
  output logic                         SERIAL_OUT_O,
  output logic                         SERIAL_OUT_OE_N,
  output logic [CHANNELS-1:0][7:0]     WIPER_LATCH,
  output logic [CHANNELS-1:0]          TERM_A_OPEN
);

  // Only one, two or four channels have a defined address map
  if (!(CHANNELS == 1 || CHANNELS == 2 || CHANNELS == 4)) begin : g_bad_channels
    $error("CHANNELS must be 1, 2 or 4");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: shift register on the serial clock

  swl_link_state_type lk_r;
  swl_link_state_type lk_nxt;

  always_comb begin
    lk_nxt = lk_r;
    if (!SELECT_N) begin
      lk_nxt.shift = {lk_r.shift[WORD_BITS-2:0], SERIAL_IN};
      if (lk_r.cnt != 4'(WORD_BITS)) begin
        lk_nxt.cnt = lk_r.cnt + BIT_CNT_ONE;
      end
    end else begin
      lk_nxt.cnt = BIT_CNT_ZERO;
    end
  end

  // Async reset only; the link clock may stop outside frames
  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: select edge sync, latches

  swl_core_state_type cr_r;
  swl_core_state_type cr_nxt;
  logic               load_evt;
  swl_word_type       word_snap;

  // Shift word is stable while select is high, so it is safe to sample
  // as the synchronised rising edge of select appears, two cycles after the raw rise.
  assign load_evt  = cr_r.sel_sync[1] & ~cr_r.sel_sync[2];
  assign word_snap = lk_r.shift;

  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.sel_sync = {cr_r.sel_sync[1:0], SELECT_N};
    cr_nxt.pd_sync  = {cr_r.pd_sync[0], POWER_DOWN_N};
    // Midscale pin is asynchronous to this clock, so it acts two cycles late
    cr_nxt.mrst_sync = {cr_r.mrst_sync[0], MIDSCALE_RESET_N};
    if (!cr_r.mrst_sync[1]) begin
      for (int i = 0; i < 4; i++) begin
        cr_nxt.latch[i] = MIDSCALE_CODE;
      end
    end else if (load_evt) begin
      if (CHANNELS == 1) begin
        cr_nxt.latch[0] = word_snap.data;
      end else begin
        case (word_snap.addr)
          ADDR_CH1: cr_nxt.latch[0] = word_snap.data;
          ADDR_CH2: cr_nxt.latch[1] = word_snap.data;
          ADDR_CH3: cr_nxt.latch[2] = word_snap.data;
          ADDR_CH4: cr_nxt.latch[3] = word_snap.data;
          default:  cr_nxt.latch[0] = word_snap.data;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cr_r <= '{sel_sync: '1, pd_sync: '1, mrst_sync: '1, latch: {4{MIDSCALE_CODE}}};
    end else if (CE) begin
      cr_r <= cr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic out_pull_low;
  // open drain, released in power-down
  // Power-down is taken from its synchroniser, never from the raw pin
  assign out_pull_low    = ~lk_r.shift[WORD_BITS-1] & cr_r.pd_sync[1];
  assign SERIAL_OUT_O    = 1'b0;
  assign SERIAL_OUT_OE_N = ~out_pull_low;

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      assign WIPER_LATCH[c] = cr_r.latch[c];
      assign TERM_A_OPEN[c] = ~cr_r.pd_sync[1];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_midscale;
    @(posedge MCLK) disable iff (!RST_N)
      (CE && !MIDSCALE_RESET_N) [*3] |=> (cr_r.latch == {4{MIDSCALE_CODE}});
  endproperty
  a_midscale: assert property (p_midscale) else $error("latch not midscale");

  property p_load;
    @(posedge MCLK) disable iff (!RST_N)
      (CE && load_evt && cr_r.mrst_sync[1] && word_snap.addr == ADDR_CH1)
        |=> (cr_r.latch[0] == $past(word_snap.data));
  endproperty
  a_load: assert property (p_load) else $error("channel one not loaded");

  property p_load_addr;
    @(posedge MCLK) disable iff (!RST_N)
      (CHANNELS != 1 && CE && load_evt && cr_r.mrst_sync[1])
        |=> (cr_r.latch[$past(word_snap.addr)] == $past(word_snap.data));
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("wrong channel loaded");

  property p_single;
    @(posedge MCLK) disable iff (!RST_N)
      (CHANNELS == 1 && CE && load_evt && cr_r.mrst_sync[1])
        |=> (WIPER_LATCH[0] == $past(lk_r.shift[DATA_BITS-1:0]));
  endproperty
  a_single: assert property (p_single) else $error("single latch not loaded");

  // Select rises between clock edges, then two enabled cycles pass the synchroniser
  sequence s_sel_rise;
    (CE && $rose(SELECT_N)) ##1 (CE [*2]);
  endsequence
  property p_only_on_edge;
    @(posedge MCLK) disable iff (!RST_N)
      (CE && cr_r.mrst_sync[1] && !load_evt) |=> $stable(cr_r.latch);
  endproperty
  a_only_on_edge: assert property (p_only_on_edge) else $error("latch moved");

  property p_edge_loads;
    @(posedge MCLK) disable iff (!RST_N) s_sel_rise |-> load_evt;
  endproperty
  a_edge_loads: assert property (p_edge_loads) else $error("edge missed");

  property p_pd;
    @(posedge MCLK) disable iff (!RST_N)
      (CE && !POWER_DOWN_N) [*3] |-> TERM_A_OPEN[0];
  endproperty
  a_pd: assert property (p_pd) else $error("A terminal not open");

  property p_pd_exit;
    @(posedge MCLK) disable iff (!RST_N)
      (CE && POWER_DOWN_N) [*3] |-> !TERM_A_OPEN[0];
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("A terminal still open");

  property p_sdo_off;
    @(posedge MCLK) disable iff (!RST_N)
      (CE && !POWER_DOWN_N) [*3] |-> SERIAL_OUT_OE_N;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("output active");

  property p_od;
    @(posedge MCLK) disable iff (!RST_N) !SERIAL_OUT_O;
  endproperty
  a_od: assert property (p_od) else $error("output drives high");

  property p_cnt_clear;
    @(posedge SCLK) disable iff (!RST_N) SELECT_N |=> (lk_r.cnt == BIT_CNT_ZERO);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");

  // Stray clock edges outside a frame must leave the word untouched
  property p_hold;
    @(posedge SCLK) disable iff (!RST_N) SELECT_N |=> $stable(lk_r.shift);
  endproperty
  a_hold: assert property (p_hold) else $error("shift while deselected");

  property p_shift;
    @(posedge SCLK) disable iff (!RST_N)
      !SELECT_N |=> (lk_r.shift[0] == $past(SERIAL_IN));
  endproperty
  a_shift: assert property (p_shift) else $error("bit not sampled");

endmodule : swl_wiper_latch_if
